// ---- ifg_pkg.sv ----
package ifg_pkg;

  // processor flag positions inside the flag word seen over the register port
  localparam int unsigned FLG_BIT_MASK_EN = 0;
  localparam int unsigned FLG_BIT_STK_SEL = 1;
  localparam int unsigned FLG_BIT_RSVD    = 2;
  localparam int unsigned FLG_LSB_PPL     = 4;
  localparam int unsigned PPL_W           = 3;

  // register port map (word index on a byte-wide address)
  localparam logic [1:0] REG_FLAGS  = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;

  // values after reset
  localparam logic             RST_MASK_EN = 1'h0;
  localparam logic             RST_STK_SEL = 1'h0;
  localparam logic [PPL_W-1:0] RST_PPL     = 3'h0;

  // software trap numbers at or below this clear the stack select flag
  localparam logic [5:0] TRAP_CLR_MAX = 6'h1F;

  // request from the priority resolver
  typedef struct packed {
    logic             valid;
    logic [PPL_W-1:0] prio;
  } ifg_req_t;

  // trap event from the sequencer
  typedef struct packed {
    logic       valid;
    logic [5:0] num;
  } ifg_trap_t;

endpackage

// ---- ifg_flags.sv ----
`timescale 1ns/1ps
// What this block does
// - maskable requests blocked while enable flag is 0, considered when 1
// - acknowledging a request clears the enable flag to 0
// - stack select 0 picks interrupt stack pointer, 1 picks user stack pointer
// - hardware acknowledge or trap number 0..31 clears stack select
// - processor priority level is a 3-bit field, levels 0 to 7
// - accept only when request priority strictly above current level
// - reserved flag bit reads as 0; software should write 0
module ifg_flags
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // register port
  input  wire logic [1:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // interrupt side
  input  ifg_pkg::ifg_req_t     irq_req,
  input  ifg_pkg::ifg_trap_t    trap_evt,
  input  wire logic             sw_ack,
  output logic                  irq_accept,
  output logic                  irq_pending,
  // stack side and flag view
  output logic                  stk_use_user,
  output logic                  mask_en,
  output logic [ifg_pkg::PPL_W-1:0] ppl
);

  typedef struct packed {
    logic                      mask_en;
    logic                      stk_sel;
    logic [ifg_pkg::PPL_W-1:0] ppl;
    logic                      accept;
    logic                      pending;
    logic [7:0]                rdata;
  } ifg_state_t;

  ifg_state_t st_reg;
  ifg_state_t st_next;
  logic       eligible;
  logic       take;

  always_comb
  begin
    st_next  = st_reg;
    // strict compare, equal level stays pending
    eligible = irq_req.valid && (irq_req.prio > st_reg.ppl);
    take     = eligible && st_reg.mask_en;
    st_next.accept  = take;
    st_next.pending = irq_req.valid && !take;
    st_next.rdata   = 8'h00;
    if (reg_wr && reg_addr == ifg_pkg::REG_FLAGS)
    begin
      // reserved bit written is simply dropped
      st_next.mask_en = reg_wdata[ifg_pkg::FLG_BIT_MASK_EN];
      st_next.stk_sel = reg_wdata[ifg_pkg::FLG_BIT_STK_SEL];
      st_next.ppl     = reg_wdata[ifg_pkg::FLG_LSB_PPL +: ifg_pkg::PPL_W];
    end
    // hardware events win over a software write in the same cycle
    if (trap_evt.valid && trap_evt.num <= ifg_pkg::TRAP_CLR_MAX)
      st_next.stk_sel = 1'h0;
    if (take || sw_ack)
    begin
      st_next.mask_en = 1'h0;
      st_next.stk_sel = 1'h0;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        ifg_pkg::REG_FLAGS:
        begin
          st_next.rdata[ifg_pkg::FLG_BIT_MASK_EN] = st_reg.mask_en;
          st_next.rdata[ifg_pkg::FLG_BIT_STK_SEL] = st_reg.stk_sel;
          st_next.rdata[ifg_pkg::FLG_BIT_RSVD]    = 1'h0;
          st_next.rdata[ifg_pkg::FLG_LSB_PPL +: ifg_pkg::PPL_W] = st_reg.ppl;
        end
        ifg_pkg::REG_STATUS:
        begin
          st_next.rdata[0] = st_reg.pending;
          st_next.rdata[1] = st_reg.accept;
        end
        default:
          st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg.mask_en <= ifg_pkg::RST_MASK_EN;
      st_reg.stk_sel <= ifg_pkg::RST_STK_SEL;
      st_reg.ppl     <= ifg_pkg::RST_PPL;
      st_reg.accept  <= 1'h0;
      st_reg.pending <= 1'h0;
      st_reg.rdata   <= 8'h00;
    end
    else
      st_reg <= st_next;
  end

  assign irq_accept   = st_reg.accept;
  assign irq_pending  = st_reg.pending;
  assign stk_use_user = st_reg.stk_sel;
  assign mask_en      = st_reg.mask_en;
  assign ppl          = st_reg.ppl;
  assign reg_rdata    = st_reg.rdata;

  property p_mask_blocks;
    @(posedge mclk) disable iff (!rstn)
    !st_reg.mask_en |=> !irq_accept;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("accept while masked");

  property p_accept_clears;
    @(posedge mclk) disable iff (!rstn)
    irq_accept |-> !mask_en && !stk_use_user;
  endproperty
  a_accept_clears: assert property (p_accept_clears) else $error("flags not cleared");

  property p_accept_cause;
    @(posedge mclk) disable iff (!rstn)
    (irq_req.valid && mask_en && irq_req.prio > ppl) |=> irq_accept;
  endproperty
  a_accept_cause: assert property (p_accept_cause) else $error("eligible not taken");

  property p_low_prio_waits;
    @(posedge mclk) disable iff (!rstn)
    (irq_req.valid && irq_req.prio <= ppl) |=> !irq_accept && irq_pending;
  endproperty
  a_low_prio_waits: assert property (p_low_prio_waits) else $error("low prio taken");

  property p_trap_low;
    @(posedge mclk) disable iff (!rstn)
    (trap_evt.valid && trap_evt.num <= 6'h1F) |=> !stk_use_user;
  endproperty
  a_trap_low: assert property (p_trap_low) else $error("low trap kept user stack");

  property p_trap_high;
    @(posedge mclk) disable iff (!rstn)
    (trap_evt.valid && trap_evt.num > 6'h1F && !reg_wr && !sw_ack && !take)
      |=> stk_use_user == $past(stk_use_user);
  endproperty
  a_trap_high: assert property (p_trap_high) else $error("high trap changed stack");

  property p_stack_select;
    @(posedge mclk) disable iff (!rstn)
    (reg_wr && reg_addr == 2'h0 && !take && !sw_ack && !trap_evt.valid)
      |=> stk_use_user == $past(reg_wdata[1]) && ppl == $past(reg_wdata[6:4]);
  endproperty
  a_stack_select: assert property (p_stack_select) else $error("flag write lost");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!rstn)
    reg_rd |=> reg_rdata[2] == 1'h0 && reg_rdata[7] == 1'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit nonzero");

  property p_ppl_read;
    @(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == 2'h0) |=> reg_rdata[6:4] == $past(ppl);
  endproperty
  a_ppl_read: assert property (p_ppl_read) else $error("level readback wrong");

  property p_accept_once;
    @(posedge mclk) disable iff (!rstn)
    irq_accept |=> !irq_accept;
  endproperty
  a_accept_once: assert property (p_accept_once) else $error("accept held");

  property p_sw_ack_clears;
    @(posedge mclk) disable iff (!rstn)
    sw_ack |=> !mask_en && !stk_use_user;
  endproperty
  a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("ack kept flags");

  property p_accept_level;
    @(posedge mclk) disable iff (!rstn)
    irq_accept |-> $past(irq_req.valid) && ($past(irq_req.prio) > $past(ppl));
  endproperty
  a_accept_level: assert property (p_accept_level) else $error("accept at low level");

  property p_accept_mask;
    @(posedge mclk) disable iff (!rstn)
    irq_accept |-> $past(mask_en);
  endproperty
  a_accept_mask: assert property (p_accept_mask) else $error("accept without enable");

  property p_idle_quiet;
    @(posedge mclk) disable iff (!rstn)
    !irq_req.valid |=> !irq_accept && !irq_pending;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("status without request");

  property p_ppl_hold;
    @(posedge mclk) disable iff (!rstn)
    !(reg_wr && reg_addr == ifg_pkg::REG_FLAGS) |=> $stable(ppl);
  endproperty
  a_ppl_hold: assert property (p_ppl_hold) else $error("level moved without write");

  property p_mask_hold;
    @(posedge mclk) disable iff (!rstn)
    (!reg_wr && !sw_ack && !take) |=> $stable(mask_en);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("enable moved on its own");

  property p_mask_set_sw;
    @(posedge mclk) disable iff (!rstn)
    $rose(mask_en) |-> $past(reg_wr) && $past(reg_wdata[ifg_pkg::FLG_BIT_MASK_EN]);
  endproperty
  a_mask_set_sw: assert property (p_mask_set_sw) else $error("enable set by hardware");

  property p_user_set_sw;
    @(posedge mclk) disable iff (!rstn)
    $rose(stk_use_user) |-> $past(reg_wr) && $past(reg_addr) == ifg_pkg::REG_FLAGS;
  endproperty
  a_user_set_sw: assert property (p_user_set_sw) else $error("user stack set by hardware");

  property p_status_read;
    @(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == ifg_pkg::REG_STATUS)
      |=> reg_rdata[1:0] == {$past(irq_accept), $past(irq_pending)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_flags_read;
    @(posedge mclk) disable iff (!rstn)
    (reg_rd && reg_addr == ifg_pkg::REG_FLAGS)
      |=> reg_rdata[1:0] == {$past(stk_use_user), $past(mask_en)};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag readback wrong");

endmodule

// ---- ifg_src.sv ----
`timescale 1ns/1ps
module ifg_src
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // control from bench
  input  wire logic        load,
  input  ifg_pkg::ifg_req_t nxt,
  // block side
  input  wire logic        irq_accept,
  output ifg_pkg::ifg_req_t irq_req
);
  // idle priority lines toggle so a stale value is never mistaken for live
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      irq_req <= '0;
    else if (load)
      irq_req <= nxt;
    else if (irq_accept)
      irq_req.valid <= 1'b0;
    else if (!irq_req.valid)
      irq_req.prio <= ~irq_req.prio;
endmodule

// ---- cpu_interrupt_flag_gating_test.sv ----
`timescale 1ns/1ps
module cpu_interrupt_flag_gating_test;
  logic mclk, rstn, reg_wr, reg_rd, sw_ack, irq_accept, irq_pending, stk_use_user, mask_en, ld;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] ppl;
  ifg_pkg::ifg_req_t irq_req, nxt;
  ifg_pkg::ifg_trap_t trap_evt;
  int err_total, n_tests;
  localparam logic [7:0] RST_VIEW =
    {3'h0, ifg_pkg::RST_STK_SEL, ifg_pkg::RST_MASK_EN, ifg_pkg::RST_PPL};
  ifg_flags ifg_flags_i (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
    .trap_evt(trap_evt), .sw_ack(sw_ack), .irq_accept(irq_accept),
    .irq_pending(irq_pending), .stk_use_user(stk_use_user), .mask_en(mask_en), .ppl(ppl));
  ifg_src ifg_src_i (.mclk(mclk), .rstn(rstn), .load(ld), .nxt(nxt),
    .irq_accept(irq_accept), .irq_req(irq_req));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask
  // load the source, then look at accept and pending after the taking edge
  task req(input logic v, input logic [2:0] p, input logic [1:0] exp);
    @(posedge mclk) {ld, nxt} <= {1'b1, v, p};
    @(posedge mclk) ld <= 1'b0;
    @(posedge mclk) #1 chk({6'h0, irq_accept, irq_pending}, {6'h0, exp});
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    #80000;
    err_total++;
    conclude;
  end
  initial
  begin
    {rstn, reg_wr, reg_rd, sw_ack, ld, reg_addr, reg_wdata, nxt, trap_evt} = '0;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(2'h0, 8'h00, 8'hFB);
    wr(2'h0, 8'h47);
    rd(2'h0, 8'h43, 8'hFB);
    chk({3'h0, stk_use_user, mask_en, ppl}, 8'h1C);
    rd(2'h2, 8'h00, 8'hFF);
    req(1'b1, 3'h4, 2'h1);
    rd(2'h1, 8'h01, 8'hFF);
    req(1'b1, 3'h5, 2'h2);
    chk({3'h0, stk_use_user, mask_en, ppl}, 8'h04);
    req(1'b1, 3'h7, 2'h1);
    wr(2'h0, 8'h71);
    req(1'b1, 3'h7, 2'h1);
    req(1'b0, 3'h0, 2'h0);
    rd(2'h1, 8'h00, 8'hFF);
    // trap numbers 63, 31 and 0: only the first leaves the user stack selected
    for (int i = 2; i >= 0; i--)
    begin
      wr(2'h0, 8'h02);
      @(posedge mclk) trap_evt <= {1'h1, 6'(i * 31 + (i == 2))};
      @(posedge mclk) trap_evt <= '0;
      #1 chk({7'h0, stk_use_user}, {7'h0, i == 2});
    end
    wr(2'h0, 8'h03);
    @(posedge mclk) sw_ack <= 1'b1;
    @(posedge mclk) sw_ack <= 1'b0;
    #1 chk({6'h0, stk_use_user, mask_en}, 8'h00);
    // mid-run reset must bring every flag back to its reset value
    wr(2'h0, 8'h73);
    @(posedge mclk) rstn <= 1'h0;
    @(posedge mclk) rstn <= 1'h1;
    #1 chk({3'h0, stk_use_user, mask_en, ppl}, RST_VIEW);
    rd(2'h0, RST_VIEW, 8'hFB);
    conclude;
  end
endmodule
